/* hw/tcp_pwm_gen.sv */
`timescale 1ns/10ps
module tcp_pwm_gen (
   input wire logic sys_clk, // core clock, 10 MHz
   input wire logic sys_rst, // synchronous reset, high
   input wire logic [4:0] reg_addr, // register address from command byte
   input wire logic [7:0] reg_wdata, // write data byte
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic reg_rd, // read strobe, one cycle
   output logic [7:0] reg_rdata, // read data, registered
   output logic [2:0] channel_pwm, // raw channel outputs
   output logic [11:0] hb_pwm, // pwm level per half-bridge output
   output logic [11:0] hb_pwm_active // output follows a channel
);
   logic [7:0] channel_frequency_select;
   logic [7:0] channel1_duty_cycle;
   logic [7:0] channel2_duty_cycle;
   logic [7:0] channel3_duty_cycle;
   logic [7:0] channel_fast_rate_override;
   logic [7:0] output_source_select1;
   logic [7:0] output_source_select2;
   logic [7:0] output_source_select3;
   logic [1:0] clock_dither_rate_select;
   logic [9:0] dither_cnt;
   logic [9:0] dither_div;
   logic dither_phase;
   logic [23:0] source_fields;
   logic [7:0] duty_of [3];
   logic [1:0] rate_of [3];
   logic [7:0] next_rdata;

   ////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         channel_frequency_select <= tcp_pkg::FREQ_RESET;
      end else if (reg_wr && reg_addr == tcp_pkg::ADDR_FREQ) begin
         channel_frequency_select <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         channel1_duty_cycle <= tcp_pkg::DUTY_RESET;
      end else if (reg_wr && reg_addr == tcp_pkg::ADDR_DUTY1) begin
         channel1_duty_cycle <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         channel2_duty_cycle <= tcp_pkg::DUTY_RESET;
      end else if (reg_wr && reg_addr == tcp_pkg::ADDR_DUTY2) begin
         channel2_duty_cycle <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         channel3_duty_cycle <= tcp_pkg::DUTY_RESET;
      end else if (reg_wr && reg_addr == tcp_pkg::ADDR_DUTY3) begin
         channel3_duty_cycle <= reg_wdata;
      end
   end

   // only the three override bits exist; the rest read as zero
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         channel_fast_rate_override <= tcp_pkg::FAST_RESET;
      end else if (reg_wr && reg_addr == tcp_pkg::ADDR_FAST) begin
         channel_fast_rate_override <= reg_wdata & tcp_pkg::FAST_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         output_source_select1 <= tcp_pkg::HBSEL_RESET;
         output_source_select2 <= tcp_pkg::HBSEL_RESET;
         output_source_select3 <= tcp_pkg::HBSEL_RESET;
      end else if (reg_wr) begin
         if (reg_addr == tcp_pkg::ADDR_HBSEL1) begin
            output_source_select1 <= reg_wdata;
         end
         if (reg_addr == tcp_pkg::ADDR_HBSEL2) begin
            output_source_select2 <= reg_wdata;
         end
         if (reg_addr == tcp_pkg::ADDR_HBSEL3) begin
            output_source_select3 <= reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register reads; unmapped addresses answer zero
   always_comb begin
      unique case (reg_addr)
         tcp_pkg::ADDR_FREQ: next_rdata = channel_frequency_select;
         tcp_pkg::ADDR_DUTY1: next_rdata = channel1_duty_cycle;
         tcp_pkg::ADDR_DUTY2: next_rdata = channel2_duty_cycle;
         tcp_pkg::ADDR_DUTY3: next_rdata = channel3_duty_cycle;
         tcp_pkg::ADDR_FAST: next_rdata = channel_fast_rate_override;
         tcp_pkg::ADDR_HBSEL1: next_rdata = output_source_select1;
         tcp_pkg::ADDR_HBSEL2: next_rdata = output_source_select2;
         tcp_pkg::ADDR_HBSEL3: next_rdata = output_source_select3;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // dither: a square wave at the modulation rate stretches duty steps
   // by one cycle in alternate half-cycles, a +/-0.25 % swing at 200 Hz
   assign clock_dither_rate_select =
      channel_frequency_select[tcp_pkg::FREQ_DITHER_LSB +: 2];

   always_comb begin
      unique case (clock_dither_rate_select)
         2'b01: dither_div = tcp_pkg::DITHER_DIV_1;
         2'b10: dither_div = tcp_pkg::DITHER_DIV_2;
         default: dither_div = tcp_pkg::DITHER_DIV_3;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || clock_dither_rate_select == 2'b00) begin
         dither_cnt <= 10'h000;
         dither_phase <= 1'b0;
      end else if (dither_cnt >= (dither_div >> 1) - 10'h001) begin
         dither_cnt <= 10'h000;
         dither_phase <= ~dither_phase;
      end else begin
         dither_cnt <= dither_cnt + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channels
   assign duty_of[0] = channel1_duty_cycle;
   assign duty_of[1] = channel2_duty_cycle;
   assign duty_of[2] = channel3_duty_cycle;
   assign rate_of[0] =
      channel_frequency_select[tcp_pkg::FREQ_CH1_LSB +: 2];
   assign rate_of[1] =
      channel_frequency_select[tcp_pkg::FREQ_CH2_LSB +: 2];
   assign rate_of[2] =
      channel_frequency_select[tcp_pkg::FREQ_CH3_LSB +: 2];

   generate
      for (genvar c = 0; c < tcp_pkg::NUM_CHANNELS; c++) begin : g_ch
         tcp_channel u_channel (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .rate_select(rate_of[c]),
            .fast_override(
               channel_fast_rate_override[tcp_pkg::FAST_CH1_BIT + c]),
            .dither_stretch(dither_phase),
            .duty_value(duty_of[c]),
            .pwm_out(channel_pwm[c])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // half-bridge routing, two select bits per output
   assign source_fields = {output_source_select3, output_source_select2,
      output_source_select1};

   generate
      for (genvar h = 0; h < tcp_pkg::NUM_OUTPUTS; h++) begin : g_hb
         logic [1:0] src;
         assign src = source_fields[2 * h +: 2];
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               hb_pwm[h] <= 1'b0;
               hb_pwm_active[h] <= 1'b0;
            end else begin
               hb_pwm_active[h] <= (src != 2'b00);
               unique case (src)
                  2'b01: hb_pwm[h] <= channel_pwm[0];
                  2'b10: hb_pwm[h] <= channel_pwm[1];
                  2'b11: hb_pwm[h] <= channel_pwm[2];
                  default: hb_pwm[h] <= 1'b0;
               endcase
            end
         end
      end
   endgenerate
endmodule : tcp_pwm_gen

/* pkg/tcp_pkg.sv */
package tcp_pkg;
   // core clock and the step count of one pwm period
   localparam int CLK_HZ = 10_000_000;
   localparam int PERIOD_STEPS = 255;
   localparam int RATE_80_HZ = 80;
   localparam int RATE_100_HZ = 100;
   localparam int RATE_200_HZ = 200;
   localparam int RATE_FAST_HZ = 2000;
   // cycles per duty step, rounded to the nearest whole cycle
   localparam logic [8:0] STEP_80 = 9'((CLK_HZ + RATE_80_HZ * PERIOD_STEPS / 2)
      / (RATE_80_HZ * PERIOD_STEPS));
   localparam logic [8:0] STEP_100 = 9'((CLK_HZ + RATE_100_HZ * PERIOD_STEPS
      / 2) / (RATE_100_HZ * PERIOD_STEPS));
   localparam logic [8:0] STEP_200 = 9'((CLK_HZ + RATE_200_HZ * PERIOD_STEPS
      / 2) / (RATE_200_HZ * PERIOD_STEPS));
   localparam logic [8:0] STEP_FAST = 9'((CLK_HZ + RATE_FAST_HZ * PERIOD_STEPS
      / 2) / (RATE_FAST_HZ * PERIOD_STEPS));
   localparam logic [7:0] LAST_PHASE = 8'(PERIOD_STEPS - 1);
   // dither (frequency modulation) rates, in mHz to keep 15.625 kHz exact
   localparam longint DITHER_1_MHZ = 15_625_000;
   localparam longint DITHER_2_MHZ = 31_250_000;
   localparam longint DITHER_3_MHZ = 62_500_000;
   localparam logic [9:0] DITHER_DIV_1 = 10'(64'(CLK_HZ) * 1000 / DITHER_1_MHZ);
   localparam logic [9:0] DITHER_DIV_2 = 10'(64'(CLK_HZ) * 1000 / DITHER_2_MHZ);
   localparam logic [9:0] DITHER_DIV_3 = 10'(64'(CLK_HZ) * 1000 / DITHER_3_MHZ);
   // register addresses (5-bit address field of the command byte)
   localparam logic [4:0] ADDR_FREQ = 5'h0C;
   localparam logic [4:0] ADDR_DUTY1 = 5'h1C;
   localparam logic [4:0] ADDR_DUTY2 = 5'h02;
   localparam logic [4:0] ADDR_DUTY3 = 5'h12;
   localparam logic [4:0] ADDR_FAST = 5'h06;
   localparam logic [4:0] ADDR_HBSEL1 = 5'h08;
   localparam logic [4:0] ADDR_HBSEL2 = 5'h04;
   localparam logic [4:0] ADDR_HBSEL3 = 5'h18;
   // frequency register fields
   localparam int FREQ_CH1_LSB = 0;
   localparam int FREQ_CH2_LSB = 2;
   localparam int FREQ_CH3_LSB = 4;
   localparam int FREQ_DITHER_LSB = 6;
   // fast-rate override bits, channel 1 at the lowest
   localparam int FAST_CH1_BIT = 4;
   localparam logic [7:0] FAST_MASK = 8'h70;
   // reset values
   localparam logic [7:0] FREQ_RESET = 8'h00;
   localparam logic [7:0] DUTY_RESET = 8'h00;
   localparam logic [7:0] FAST_RESET = 8'h00;
   localparam logic [7:0] HBSEL_RESET = 8'h00;
   localparam int NUM_CHANNELS = 3;
   localparam int NUM_OUTPUTS = 12;
endpackage : tcp_pkg

/* hw/tcp_channel.sv */
`timescale 1ns/10ps
module tcp_channel (
   input wire logic sys_clk, // core clock
   input wire logic sys_rst, // synchronous reset, high
   input wire logic [1:0] rate_select, // 00 stop unless fast_override, 01/10/11 base rates
   input wire logic fast_override, // forces the fast rate
   input wire logic dither_stretch, // lengthen each duty step by one cycle
   input wire logic [7:0] duty_value, // on time in 255ths
   output logic pwm_out // channel output, registered
);
   logic [8:0] step_cnt;
   logic [8:0] step_len;
   logic [7:0] phase;
   logic halted;
   logic step_done;

   assign halted = (rate_select == 2'b00) && !fast_override;
   assign step_done = (step_cnt >= step_len - 9'h001);

   always_comb begin
      if (fast_override) begin
         step_len = tcp_pkg::STEP_FAST;
      end else begin
         unique case (rate_select)
            2'b01: step_len = tcp_pkg::STEP_80;
            2'b10: step_len = tcp_pkg::STEP_100;
            default: step_len = tcp_pkg::STEP_200;
         endcase
      end
      // dither spreads the spectrum by alternating step lengths
      if (dither_stretch) begin
         step_len = step_len + 9'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk) begin
      if (sys_rst || halted) begin
         step_cnt <= 9'h000;
      end else if (step_done) begin
         step_cnt <= 9'h000;
      end else begin
         step_cnt <= step_cnt + 9'h001;
      end
   end

   // 255 steps a period: phase runs 0..254
   always_ff @(posedge sys_clk) begin
      if (sys_rst || halted) begin
         phase <= 8'h00;
      end else if (step_done) begin
         phase <= (phase == tcp_pkg::LAST_PHASE) ? 8'h00 : phase + 8'h01;
      end
   end

   // duty 0 never beats phase, duty 255 always does
   always_ff @(posedge sys_clk) begin
      if (sys_rst || halted) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= (phase < duty_value);
      end
   end
endmodule : tcp_channel

/* dv/tcp_pwm_gen_sva.sv */
`timescale 1ns/10ps
module tcp_pwm_gen_sva (
   input wire logic sys_clk, // clock
   input wire logic sys_rst, // reset
   input wire logic [4:0] reg_addr, // address
   input wire logic [7:0] reg_wdata, // wdata
   input wire logic reg_wr, // write
   input wire logic reg_rd, // read
   input wire logic [7:0] reg_rdata, // rdata
   input wire logic [2:0] channel_pwm, // channels
   input wire logic [11:0] hb_pwm, // levels
   input wire logic [11:0] hb_pwm_active // in use
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   logic [7:0] d1;
   logic [1:0] r1;
   logic ov1;
   wire run1 = (r1 != 2'b00) || ov1;
   ////////////////////////////////////////
   // shadow of channel 1 setup, so outputs can be tied to their cause
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         d1 <= 8'h00;
         r1 <= 2'b00;
         ov1 <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == tcp_pkg::ADDR_DUTY1) d1 <= reg_wdata;
         if (reg_addr == tcp_pkg::ADDR_FREQ)
            r1 <= reg_wdata[tcp_pkg::FREQ_CH1_LSB +: 2];
         if (reg_addr == tcp_pkg::ADDR_FAST)
            ov1 <= reg_wdata[tcp_pkg::FAST_CH1_BIT];
      end
   end
   ////////////////////////////////////////
   a_reset_clears: assert property (disable iff (1'b0) sys_rst |=>
      channel_pwm == 3'h0 && hb_pwm_active == 12'h000)
      else $error("reset left outputs on");
   a_halt_off: assert property ((!run1) [*2] |-> !channel_pwm[0])
      else $error("halted channel on");
   a_full_on: assert property ((run1 && d1 == 8'hFF) [*3] |->
      channel_pwm[0]) else $error("full duty not on");
   a_zero_off: assert property ((d1 == 8'h00) [*2] |-> !channel_pwm[0])
      else $error("zero duty not off");
   a_read_duty: assert property (reg_rd && reg_addr == tcp_pkg::ADDR_DUTY1
      |=> reg_rdata == $past(d1)) else $error("duty readback wrong");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved");
   a_fast_mask: assert property (reg_rd && reg_addr == tcp_pkg::ADDR_FAST
      |=> (reg_rdata & ~tcp_pkg::FAST_MASK) == 8'h00)
      else $error("override spare bits set");
   a_hb_gated: assert property ((hb_pwm & ~hb_pwm_active) == 12'h000)
      else $error("unused output on");
   a_hb_source: assert property (hb_pwm != 12'h000 |->
      $past(channel_pwm) != 3'h0) else $error("output on without channel");
   c_full: cover property (channel_pwm[0] && d1 == 8'hFF);
   c_route: cover property (hb_pwm_active[2:0] == 3'b111);
   c_fast_read: cover property (reg_rd && reg_addr == tcp_pkg::ADDR_FAST);
endmodule : tcp_pwm_gen_sva

/* dv/tcp_hb_stage.sv */
`timescale 1ns/10ps
module tcp_hb_stage (
   input wire logic sys_clk, // clock
   input wire logic clr, // restart tally
   input wire logic [11:0] hb_pwm, // levels
   input wire logic [11:0] hb_pwm_active, // in use
   output int on_cycles // cycles output 1 was driven on
);
   // output 1 only: one stage is enough to measure the on time
   always @(posedge sys_clk) begin
      if (clr) on_cycles <= 0;
      else if (hb_pwm_active[0] && hb_pwm[0]) on_cycles <= on_cycles + 1;
   end
endmodule : tcp_hb_stage

/* dv/tb.sv */
`timescale 1ns/10ps
module tb;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [4:0] reg_addr = 5'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic clr = 1'b1;
   logic [7:0] reg_rdata;
   logic [7:0] rv;
   logic [2:0] channel_pwm;
   logic [11:0] hb_pwm;
   logic [11:0] hb_pwm_active;
   int on_cycles;
   int n_fail = 0;
   int total_checks = 0;
   always #50 sys_clk = ~sys_clk;
   tcp_pwm_gen tcp_pwm_gen_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_pwm(channel_pwm),
      .hb_pwm(hb_pwm), .hb_pwm_active(hb_pwm_active));
   tcp_hb_stage tcp_hb_stage_inst (.sys_clk(sys_clk), .clr(clr),
      .hb_pwm(hb_pwm), .hb_pwm_active(hb_pwm_active), .on_cycles(on_cycles));
   ////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // a strobe stays low for a cycle between requests, never re-raised at once
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      rv = reg_rdata;
   endtask : rd
   ////////////////////////////////////////
   task automatic t_halt;
      wr(tcp_pkg::ADDR_DUTY1, 8'hFF);
      repeat (20) @(negedge sys_clk);
      check("halted", channel_pwm, 3'h0);
      $display("test halt done");
   endtask : t_halt
   task automatic t_regs;
      rd(tcp_pkg::ADDR_FREQ);
      check("freq_reset", rv, 8'h00);
      rd(tcp_pkg::ADDR_DUTY2);
      check("duty2_reset", rv, 8'h00);
      wr(tcp_pkg::ADDR_DUTY1, 8'hA5);
      wr(tcp_pkg::ADDR_DUTY2, 8'h5A);
      wr(tcp_pkg::ADDR_FREQ, 8'hE4);
      wr(tcp_pkg::ADDR_FAST, 8'hFF);
      wr(5'h1F, 8'hFF);
      rd(tcp_pkg::ADDR_DUTY1);
      check("duty1", rv, 8'hA5);
      rd(tcp_pkg::ADDR_DUTY2);
      check("duty2", rv, 8'h5A);
      rd(tcp_pkg::ADDR_FREQ);
      check("freq", rv, 8'hE4);
      rd(tcp_pkg::ADDR_FAST);
      check("fast", rv, 8'h70);
      rd(5'h1F);
      check("unmapped", rv, 8'h00);
      $display("test regs done");
   endtask : t_regs
   // duty 1 gives one step high right after start, then a long low stretch
   task automatic t_rates(input logic [7:0] fsel, input logic [8:0] e1,
      input logic [8:0] e2, input logic [8:0] e3);
      int c[3] = '{0, 0, 0};
      wr(tcp_pkg::ADDR_FAST, 8'h00);
      wr(tcp_pkg::ADDR_FREQ, 8'h00);
      wr(tcp_pkg::ADDR_DUTY1, 8'h01);
      wr(tcp_pkg::ADDR_DUTY2, 8'h01);
      wr(tcp_pkg::ADDR_DUTY3, 8'h01);
      wr(tcp_pkg::ADDR_FREQ, fsel);
      repeat (600) begin
         @(negedge sys_clk);
         for (int k = 0; k < 3; k++) c[k] += int'(channel_pwm[k]);
      end
      check("ch1_step", 16'(c[0]), 16'(e1));
      check("ch2_step", 16'(c[1]), 16'(e2));
      check("ch3_step", 16'(c[2]), 16'(e3));
      $display("test rates done");
   endtask : t_rates
   // duty 2 at 200 Hz: one of the first two steps meets a dither half-cycle
   // and grows by one cycle, so the on time is one cycle over two steps
   task automatic t_dither(input logic [7:0] fsel);
      int c = 0;
      wr(tcp_pkg::ADDR_FREQ, 8'h00);
      wr(tcp_pkg::ADDR_FAST, 8'h00);
      wr(tcp_pkg::ADDR_DUTY1, 8'h02);
      wr(tcp_pkg::ADDR_FREQ, fsel);
      repeat (600) begin
         @(negedge sys_clk);
         c += int'(channel_pwm[0]);
      end
      check("dither_on", 16'(c), 16'(2 * tcp_pkg::STEP_200 + 1));
      $display("test dither done");
   endtask : t_dither
   task automatic t_duty(input logic [7:0] d);
      wr(tcp_pkg::ADDR_DUTY1, d);
      repeat (400) @(negedge sys_clk);
      clr = 1'b0;
      repeat (255 * tcp_pkg::STEP_FAST) @(negedge sys_clk);
      clr = 1'b1;
      check("on_time", 16'(on_cycles), 16'(int'(d) * tcp_pkg::STEP_FAST));
      $display("test duty done");
   endtask : t_duty
   task automatic t_route;
      wr(tcp_pkg::ADDR_FAST, 8'h30);
      wr(tcp_pkg::ADDR_HBSEL1, 8'h39);
      wr(tcp_pkg::ADDR_HBSEL2, 8'h02);
      wr(tcp_pkg::ADDR_HBSEL3, 8'h40);
      wr(tcp_pkg::ADDR_DUTY2, 8'h00);
      wr(tcp_pkg::ADDR_DUTY1, 8'hFF);
      repeat (4) @(negedge sys_clk);
      check("hb_active", hb_pwm_active, 12'h817);
      check("hb_ch1", hb_pwm, 12'h801);
      wr(tcp_pkg::ADDR_DUTY1, 8'h00);
      wr(tcp_pkg::ADDR_DUTY2, 8'hFF);
      repeat (4) @(negedge sys_clk);
      check("hb_ch2", hb_pwm, 12'h012);
      $display("test route done");
   endtask : t_route
   ////////////////////////////////////////
   initial begin
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      t_halt;
      t_regs;
      t_rates(8'h1B, tcp_pkg::STEP_200, tcp_pkg::STEP_100, tcp_pkg::STEP_80);
      t_rates(8'h39, tcp_pkg::STEP_80, tcp_pkg::STEP_100, tcp_pkg::STEP_200);
      t_dither(8'h43);
      t_dither(8'h83);
      wr(tcp_pkg::ADDR_FREQ, 8'h00);
      wr(tcp_pkg::ADDR_FAST, 8'h10);
      wr(tcp_pkg::ADDR_HBSEL1, 8'h01);
      t_duty(8'h00);
      t_duty(8'h80);
      t_duty(8'hFF);
      t_route;
      conclude;
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_fail++;
      conclude;
   end
endmodule : tb
bind tcp_pwm_gen tcp_pwm_gen_sva tcp_pwm_gen_sva_inst (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .channel_pwm(channel_pwm), .hb_pwm(hb_pwm), .hb_pwm_active(hb_pwm_active));
